// file: mrs_pkg.sv
// Purpose: shared constants, types and helpers of the serial query/response link
// Assumes: single 125 MHz clock, power-on reset
// Notes: the rate, timing, frame and alarm figures live here once; the reply store depth is set in mrs_link; the top derives its cycle counts
package mrs_pkg;

   // ==========================================================
   // clock and line rates
   localparam int CLK_HZ = 125_000_000;
   localparam int CLK_PERIOD_NS = 8;
   localparam int RATE_N = 5;
   localparam int RATE_BPS [RATE_N] = '{9600, 19200, 38400, 57600, 115200};
   localparam int FAST_RATE_BPS = 19200;

   // ==========================================================
   // silent interval and reply delay
   localparam int CHAR_BITS = 11;       // start, 8 data, parity or 2nd stop, stop
   localparam int T35_HALF_CHARS = 7;   // 3.5 characters counted in halves
   localparam int T35_FAST_US = 1750;   // fixed interval used in place of 3.5 characters at fast rates
   localparam int WAIT_UNIT_US = 100;   // one step of the reply waiting time
   localparam logic [13:0] WAIT_MAX = 14'h2710;

   // ==========================================================
   // character and frame layout
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_EVEN = 2'h1;
   localparam logic [1:0] PAR_ODD = 2'h2;
   localparam logic [7:0] BCAST_ADDR = 8'h00;
   localparam logic [2:0] MIN_FRAME_LEN = 3'h4;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'hA001;
   localparam logic [15:0] CRC_RESIDUE = 16'h0000;

   // ==========================================================
   // error alarm and power-up capture
   localparam logic [3:0] ERR_LIMIT_MIN = 4'h1;
   localparam logic [3:0] ERR_LIMIT_MAX = 4'hA;
   localparam logic [3:0] ERR_LIMIT_DEF = 4'h3;
   localparam logic [1:0] CFG_SETTLE = 2'h3;
   localparam logic [29:0] SYNC_RST = 30'h0000_0001;  // line idles high

   // ==========================================================
   // state machines
   typedef enum {MRS_RX_IDLE, MRS_RX_BITS} mrs_rx_st_t;
   typedef enum {MRS_TX_IDLE, MRS_TX_WAIT, MRS_TX_LOAD, MRS_TX_BITS} mrs_tx_st_t;

   // one byte of the reflected crc-16 used by rtu framing
   function automatic logic [15:0] mrs_crc_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

endpackage

// file: mrs_mem.sv
// Purpose: response byte store of the serial link
// Assumes: one write and one read port on the same clock
// Notes: read data come out of a register, one cycle after the address
module mrs_mem #(
   parameter int DEPTH = 256,
   parameter int AW = 8
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [7:0] rd_data
);
   logic [7:0] mem_q [DEPTH];
   logic [7:0] rd_q;

   // storage array, no reset needed: read only after a write
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem_q[wr_addr] <= wr_data;
      end
   end

   // registered read port
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_q <= 8'h00;
      end else begin
         rd_q <= mem_q[rd_addr];
      end
   end

   assign rd_data = rd_q;
endmodule // mrs_mem

// file: mrs_link.sv
// Purpose: slave end of a half-duplex rtu query/response serial link
// Assumes: line pins and setting straps are asynchronous; user logic is on clk
// Notes: received bytes stream out; the reply is written byte-wise, crc appended here

// What this block does
// - the link never transmits unless a query addressed to it is waiting for a reply.
// - a clean query addressed to this slave is handed to the user and permits one reply.
// - frames follow rtu rules: silence-delimited characters closed by a crc-16.
// - the bit rate is one of five selectable rates, the same at both ends.
// - characters carry 8 data bits, one or two stop bits and none, even or odd parity.
// - rate, parity, stop length and address take effect only at power-up.
// - a broadcast query (address zero) is executed but never answered.
// - a reply waits for the silent interval, processing and a set 0.1 ms step delay.
// - bad frames addressed to this slave or broadcast are counted and raise an alarm at a limit of 1 to 10, default 3.
module mrs_link #(
   parameter int CLK_HZ = mrs_pkg::CLK_HZ,
   parameter int TICK_CYC = CLK_HZ / 1_000_000 * mrs_pkg::WAIT_UNIT_US,
   parameter int DEPTH = 256,
   parameter int AW = 8
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic rx_pin,
   input wire logic [2:0] cfg_rate,
   input wire logic [1:0] cfg_parity,
   input wire logic cfg_stop2,
   input wire logic [4:0] cfg_addr,
   input wire logic [13:0] cfg_wait,
   input wire logic [3:0] cfg_err_limit,
   input wire logic err_clr,
   input wire logic [7:0] rsp_data,
   input wire logic rsp_wr,
   input wire logic rsp_send,
   output logic tx_pin,
   output logic tx_oe,
   output logic [7:0] rx_data,
   output logic rx_valid,
   output logic rx_end,
   output logic rx_good,
   output logic rx_bcast,
   output logic rsp_pend,
   output logic tx_busy,
   output logic comm_alarm,
   output logic [3:0] err_count
);
   localparam int T35_FAST_CYC = (CLK_HZ / 1000 * mrs_pkg::T35_FAST_US + 999) / 1000;

   // ==========================================================
   // input synchronisers
   logic [29:0] sy1_q, sy2_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sy1_q <= mrs_pkg::SYNC_RST;
         sy2_q <= mrs_pkg::SYNC_RST;
      end else begin
         sy1_q <= {cfg_rate, cfg_parity, cfg_stop2, cfg_addr, cfg_err_limit, cfg_wait, rx_pin};
         sy2_q <= sy1_q;
      end
   end
   wire rx_s = sy2_q[0];
   wire [13:0] wait_s = sy2_q[14:1];
   wire [3:0] lim_s = sy2_q[18:15];

   // ==========================================================
   // power-up capture of line settings, later strap moves are ignored
   logic [1:0] settle_q;
   logic cfg_done_q, stop2_q;
   logic [2:0] rate_q;
   logic [1:0] par_q;
   logic [4:0] addr_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         settle_q <= 2'h0;
         cfg_done_q <= 1'b0;
         rate_q <= 3'h0;
         par_q <= mrs_pkg::PAR_NONE;
         stop2_q <= 1'b0;
         addr_q <= 5'h00;
      end else if (!cfg_done_q) begin
         settle_q <= settle_q + 2'h1;
         if (settle_q == mrs_pkg::CFG_SETTLE) begin
            cfg_done_q <= 1'b1;
            rate_q <= sy2_q[29:27];
            par_q <= sy2_q[26:25];
            stop2_q <= sy2_q[24];
            addr_q <= sy2_q[23:19];
         end
      end
   end

   // ==========================================================
   // per-rate bit divisor and silent interval
   logic [13:0] div_tab [mrs_pkg::RATE_N];
   logic [19:0] t35_tab [mrs_pkg::RATE_N];
   for (genvar g = 0; g < mrs_pkg::RATE_N; g++) begin : g_rate
      localparam int RB = mrs_pkg::RATE_BPS[g];
      localparam int DIV = (CLK_HZ + RB / 2) / RB;
      localparam int T35 = (mrs_pkg::CHAR_BITS * mrs_pkg::T35_HALF_CHARS * DIV + 1) / 2;
      assign div_tab[g] = 14'(DIV);
      assign t35_tab[g] = (RB >= mrs_pkg::FAST_RATE_BPS) ? 20'(T35_FAST_CYC) : 20'(T35);
   end

   // unused rate codes fall back to the slowest rate
   wire [2:0] rate_i = (rate_q > 3'h4) ? 3'h0 : rate_q;
   wire [13:0] div = div_tab[rate_i];
   wire [19:0] t35 = t35_tab[rate_i];
   wire par_en = (par_q == mrs_pkg::PAR_EVEN) || (par_q == mrs_pkg::PAR_ODD);
   wire par_odd = par_q == mrs_pkg::PAR_ODD;
   wire lim_bad = (lim_s < mrs_pkg::ERR_LIMIT_MIN) || (lim_s > mrs_pkg::ERR_LIMIT_MAX);
   wire [3:0] lim = lim_bad ? mrs_pkg::ERR_LIMIT_DEF : lim_s;
   wire [13:0] wait_c = (wait_s > mrs_pkg::WAIT_MAX) ? mrs_pkg::WAIT_MAX : wait_s;

   // ==========================================================
   // character receiver, samples mid-bit
   mrs_pkg::mrs_rx_st_t rx_st_q;
   logic [13:0] rx_cnt_q;
   logic [3:0] rx_idx_q;
   logic [7:0] rx_sh_q;
   logic rx_par_q;
   wire rx_tick = rx_cnt_q == 14'h0000;
   wire [3:0] rx_last = par_en ? 4'hA : 4'h9;
   wire rx_done = (rx_st_q == mrs_pkg::MRS_RX_BITS) && rx_tick && (rx_idx_q == rx_last);
   wire rx_bad = !rx_s || (par_en && (rx_par_q != par_odd));
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx_st_q <= mrs_pkg::MRS_RX_IDLE;
         rx_cnt_q <= 14'h0000;
         rx_idx_q <= 4'h0;
         rx_sh_q <= 8'h00;
         rx_par_q <= 1'b0;
      end else begin
         case (rx_st_q)
            mrs_pkg::MRS_RX_IDLE: begin
               if (cfg_done_q && !rx_s) begin
                  rx_st_q <= mrs_pkg::MRS_RX_BITS;
                  rx_cnt_q <= div >> 1;
                  rx_idx_q <= 4'h0;
                  rx_par_q <= 1'b0;
               end
            end
            mrs_pkg::MRS_RX_BITS: begin
               if (!rx_tick) begin
                  rx_cnt_q <= rx_cnt_q - 14'h0001;
               end else begin
                  rx_cnt_q <= div - 14'h0001;
                  rx_idx_q <= rx_idx_q + 4'h1;
                  if (rx_idx_q >= 4'h1 && rx_idx_q <= 4'h8) begin
                     rx_sh_q <= {rx_s, rx_sh_q[7:1]};
                  end
                  if (rx_idx_q >= 4'h1 && rx_idx_q <= 4'h9) begin
                     rx_par_q <= rx_par_q ^ rx_s;
                  end
                  // a start bit gone high at mid-bit was a glitch
                  if ((rx_idx_q == 4'h0 && rx_s) || rx_done) begin
                     rx_st_q <= mrs_pkg::MRS_RX_IDLE;
                  end
               end
            end
            default: rx_st_q <= mrs_pkg::MRS_RX_IDLE;
         endcase
      end
   end

   // ==========================================================
   // frame delimiting by silence, address match and crc
   logic [19:0] idle_q;
   logic armed_q, in_frm_q, take_q, bcast_q, ferr_q;
   logic [15:0] crc_q;
   logic [2:0] len_q;
   logic rx_valid_q, rx_end_q, rx_good_q, rx_bcast_q, rsp_pend_q;
   logic [7:0] rx_data_q;
   mrs_pkg::mrs_tx_st_t tx_st_q;
   wire rx_act = (rx_st_q != mrs_pkg::MRS_RX_IDLE) || !rx_s;
   wire quiet = idle_q == t35;
   wire frm_end = in_frm_q && quiet;
   wire first = rx_done && armed_q;
   wire is_bc = rx_sh_q == mrs_pkg::BCAST_ADDR;
   wire hit = (rx_sh_q == {3'h0, addr_q}) || is_bc;
   wire [15:0] crc_nx = mrs_pkg::mrs_crc_byte(first ? mrs_pkg::CRC_INIT : crc_q, rx_sh_q);
   wire frm_ok = !ferr_q && (crc_q == mrs_pkg::CRC_RESIDUE) && (len_q == mrs_pkg::MIN_FRAME_LEN);
   wire good_end = frm_end && take_q && frm_ok;
   wire err_ev = frm_end && take_q && !frm_ok;
   wire send_ok = rsp_send && rsp_pend_q && (tx_st_q == mrs_pkg::MRS_TX_IDLE);

   // silence timer, any line activity restarts it
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         idle_q <= 20'h00000;
         armed_q <= 1'b0;
      end else begin
         idle_q <= (rx_act || !cfg_done_q) ? 20'h00000 : (quiet ? idle_q : idle_q + 20'h00001);
         armed_q <= rx_done ? 1'b0 : (armed_q || quiet);
      end
   end

   // frame accumulation
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         in_frm_q <= 1'b0;
         take_q <= 1'b0;
         bcast_q <= 1'b0;
         ferr_q <= 1'b0;
         crc_q <= mrs_pkg::CRC_INIT;
         len_q <= 3'h0;
      end else if (first) begin
         in_frm_q <= 1'b1;
         take_q <= hit;
         bcast_q <= is_bc;
         ferr_q <= rx_bad;
         crc_q <= crc_nx;
         len_q <= 3'h1;
      end else if (rx_done && in_frm_q) begin
         ferr_q <= ferr_q || rx_bad;
         crc_q <= crc_nx;
         len_q <= (len_q == mrs_pkg::MIN_FRAME_LEN) ? len_q : len_q + 3'h1;
      end else if (frm_end) begin
         in_frm_q <= 1'b0;
      end
   end

   // user-facing stream and reply permission; a set beats a clear
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx_valid_q <= 1'b0;
         rx_data_q <= 8'h00;
         rx_end_q <= 1'b0;
         rx_good_q <= 1'b0;
         rx_bcast_q <= 1'b0;
         rsp_pend_q <= 1'b0;
      end else begin
         rx_valid_q <= rx_done && (first ? hit : (in_frm_q && take_q));
         rx_data_q <= rx_sh_q;
         rx_end_q <= frm_end && take_q;
         rx_good_q <= good_end;
         rx_bcast_q <= frm_end && take_q && bcast_q;
         if (good_end && !bcast_q) begin
            rsp_pend_q <= 1'b1;
         end else if (first || send_ok) begin
            rsp_pend_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // reply store
   logic [AW:0] wcnt_q;
   logic [AW:0] tx_idx_q;
   logic [7:0] rd_data;
   wire wr_ok = rsp_wr && rsp_pend_q && (tx_st_q == mrs_pkg::MRS_TX_IDLE) && (wcnt_q < DEPTH);
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wcnt_q <= '0;
      end else if (good_end) begin
         wcnt_q <= '0;
      end else if (wr_ok) begin
         wcnt_q <= wcnt_q + 1'b1;
      end
   end

   mrs_mem #(.DEPTH(DEPTH), .AW(AW)) i_mrs_mem (
      .clk(clk),
      .rstn(rstn),
      .wr_en(wr_ok),
      .wr_addr(wcnt_q[AW-1:0]),
      .wr_data(rsp_data),
      .rd_addr(tx_idx_q[AW-1:0]),
      .rd_data(rd_data)
   );

   // ==========================================================
   // reply transmitter: wait, then stored bytes, then crc low and high
   logic [13:0] tx_cnt_q, tick_q, wleft_q;
   logic [11:0] tx_sh_q;
   logic [3:0] tx_nb_q;
   logic [15:0] tcrc_q;
   logic tx_pin_q, tx_oe_q, tx_busy_q;
   wire is_dat = tx_idx_q < wcnt_q;
   wire [7:0] tx_b = is_dat ? rd_data : ((tx_idx_q == wcnt_q) ? tcrc_q[7:0] : tcrc_q[15:8]);
   wire tx_p = (^tx_b) ^ par_odd;
   wire [11:0] tx_frame = par_en ? {2'b11, tx_p, tx_b, 1'b0} : {3'b111, tx_b, 1'b0};
   wire [3:0] tx_nbits = 4'h9 + {3'h0, par_en} + {3'h0, stop2_q};
   wire tx_last = tx_idx_q == (wcnt_q + 2'h2);
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_st_q <= mrs_pkg::MRS_TX_IDLE;
         tx_cnt_q <= 14'h0000;
         tick_q <= 14'h0000;
         wleft_q <= 14'h0000;
         tx_idx_q <= '0;
         tx_sh_q <= 12'hFFF;
         tx_nb_q <= 4'h0;
         tcrc_q <= mrs_pkg::CRC_INIT;
         tx_pin_q <= 1'b1;
         tx_oe_q <= 1'b0;
         tx_busy_q <= 1'b0;
      end else begin
         case (tx_st_q)
            mrs_pkg::MRS_TX_IDLE: begin
               if (send_ok) begin
                  tx_st_q <= mrs_pkg::MRS_TX_WAIT;
                  wleft_q <= wait_c;
                  tick_q <= 14'(TICK_CYC - 1);
                  tx_idx_q <= '0;
                  tcrc_q <= mrs_pkg::CRC_INIT;
                  tx_busy_q <= 1'b1;
               end
            end
            mrs_pkg::MRS_TX_WAIT: begin
               // frame end already needed a full silent interval
               if (wleft_q == 14'h0000) begin
                  tx_st_q <= mrs_pkg::MRS_TX_LOAD;
               end else if (tick_q == 14'h0000) begin
                  tick_q <= 14'(TICK_CYC - 1);
                  wleft_q <= wleft_q - 14'h0001;
               end else begin
                  tick_q <= tick_q - 14'h0001;
               end
            end
            mrs_pkg::MRS_TX_LOAD: begin
               tx_oe_q <= 1'b1;
               tx_pin_q <= 1'b0;
               tx_sh_q <= tx_frame;
               tx_nb_q <= tx_nbits;
               tx_cnt_q <= div - 14'h0001;
               tx_idx_q <= tx_idx_q + 1'b1;
               if (is_dat) begin
                  tcrc_q <= mrs_pkg::mrs_crc_byte(tcrc_q, tx_b);
               end
               tx_st_q <= mrs_pkg::MRS_TX_BITS;
            end
            mrs_pkg::MRS_TX_BITS: begin
               if (tx_cnt_q != 14'h0000) begin
                  tx_cnt_q <= tx_cnt_q - 14'h0001;
               end else if (tx_nb_q != 4'h0) begin
                  tx_sh_q <= {1'b1, tx_sh_q[11:1]};
                  tx_pin_q <= tx_sh_q[1];
                  tx_nb_q <= tx_nb_q - 4'h1;
                  tx_cnt_q <= div - 14'h0001;
               end else if (tx_last) begin
                  tx_st_q <= mrs_pkg::MRS_TX_IDLE;
                  tx_oe_q <= 1'b0;
                  tx_pin_q <= 1'b1;
                  tx_busy_q <= 1'b0;
               end else begin
                  tx_st_q <= mrs_pkg::MRS_TX_LOAD;
               end
            end
            default: tx_st_q <= mrs_pkg::MRS_TX_IDLE;
         endcase
      end
   end

   // ==========================================================
   // error counter and alarm; an error in the clearing cycle still counts
   logic [3:0] err_cnt_q;
   logic alarm_q;
   wire [3:0] cnt_base = err_clr ? 4'h0 : err_cnt_q;
   wire [3:0] cnt_nx = (cnt_base == mrs_pkg::ERR_LIMIT_MAX) ? cnt_base : cnt_base + 4'h1;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         err_cnt_q <= 4'h0;
         alarm_q <= 1'b0;
      end else if (err_ev) begin
         err_cnt_q <= cnt_nx;
         alarm_q <= (cnt_nx >= lim) || (alarm_q && !err_clr);
      end else if (err_clr) begin
         err_cnt_q <= 4'h0;
         alarm_q <= 1'b0;
      end
   end

   assign tx_pin = tx_pin_q;
   assign tx_oe = tx_oe_q;
   assign rx_data = rx_data_q;
   assign rx_valid = rx_valid_q;
   assign rx_end = rx_end_q;
   assign rx_good = rx_good_q;
   assign rx_bcast = rx_bcast_q;
   assign rsp_pend = rsp_pend_q;
   assign tx_busy = tx_busy_q;
   assign comm_alarm = alarm_q;
   assign err_count = err_cnt_q;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_send_wait;
      send_ok && (wait_c != 14'h0000);
   endsequence
   property p_no_unsolicited;
      (tx_st_q == mrs_pkg::MRS_TX_IDLE) && !rsp_pend_q |=> tx_st_q == mrs_pkg::MRS_TX_IDLE;
   endproperty
   a_no_unsolicited: assert property (p_no_unsolicited) else $error("tx left idle unasked");
   property p_good_pend;
      rx_good_q && !rx_bcast_q |-> rsp_pend_q;
   endproperty
   a_good_pend: assert property (p_good_pend) else $error("good query gave no reply permit");
   property p_bit_time;
      $fell(tx_pin_q) && tx_oe_q |-> ##1 (!tx_pin_q)[*8];
   endproperty
   a_bit_time: assert property (p_bit_time) else $error("start bit too short");
   property p_start_bit;
      tx_st_q == mrs_pkg::MRS_TX_LOAD |=> !tx_pin_q && tx_oe_q;
   endproperty
   a_start_bit: assert property (p_start_bit) else $error("character without start bit");
   property p_cfg_frozen;
      cfg_done_q |=> $stable(rate_q) && $stable(par_q) && $stable(stop2_q) && $stable(addr_q);
   endproperty
   a_cfg_frozen: assert property (p_cfg_frozen) else $error("line settings moved after power-up");
   property p_bcast_silent;
      rx_end_q && rx_bcast_q |-> !rsp_pend_q ##1 !tx_oe_q;
   endproperty
   a_bcast_silent: assert property (p_bcast_silent) else $error("broadcast permits a reply");
   property p_wait_hold;
      s_send_wait |=> (tx_st_q == mrs_pkg::MRS_TX_WAIT && !tx_oe_q)[*8];
   endproperty
   a_wait_hold: assert property (p_wait_hold) else $error("reply left before its wait");
   property p_alarm;
      err_ev && (cnt_nx >= lim) |=> alarm_q && (err_cnt_q == $past(cnt_nx));
   endproperty
   a_alarm: assert property (p_alarm) else $error("error limit reached without alarm");
   property p_oe_only_tx;
      tx_oe_q |-> tx_busy_q && (tx_st_q inside {mrs_pkg::MRS_TX_LOAD, mrs_pkg::MRS_TX_BITS});
   endproperty
   a_oe_only_tx: assert property (p_oe_only_tx) else $error("driver on outside a reply");
endmodule // mrs_link

// file: mrs_master.sv
// Purpose: master end of the rtu line, sends queries and reads replies
// Assumes: 8 data bits, even parity, one stop bit, DIV clock cycles per bit
// Notes: the line idles high through its bias resistors when nobody drives
module mrs_master #(
   parameter int DIV = 11
) (
   input wire logic clk,
   input wire logic line_in,
   output logic line_out
);
   timeunit 1ns;
   timeprecision 100ps;

   initial line_out = 1'b1;

   // ==========================================================
   // crc over the low n bytes of q, first byte in the top one
   function automatic logic [15:0] crc(input logic [31:0] q, input int n);
      logic [15:0] r;
      r = mrs_pkg::CRC_INIT;
      for (int i = 0; i < n; i++) begin
         r ^= {8'h00, q[8*(n-1-i) +: 8]};
         for (int k = 0; k < 8; k++) r = r[0] ? (r >> 1) ^ mrs_pkg::CRC_POLY : r >> 1;
      end
      return r;
   endfunction

   // one character: start, data lsb first, even parity, stop
   task automatic put(input logic [7:0] b);
      logic [10:0] f;
      f = {1'b1, ^b, b, 1'b0};
      for (int i = 0; i < 11; i++) begin
         line_out = f[i];
         repeat (DIV) @(posedge clk);
         #1;
      end
   endtask

   // only the master opens a transaction; bad flips one crc bit
   task automatic query(input logic [31:0] q, input logic bad);
      logic [15:0] c;
      c = crc(q, 4);
      for (int i = 3; i >= 0; i--) put(q[8*i +: 8]);
      put(c[7:0] ^ {7'h00, bad});
      put(c[15:8]);
   endtask

   // one reply character sampled mid-bit; framing and parity judged here
   task automatic get(output logic [7:0] b, output logic ok);
      logic [9:0] f;
      wait (line_in === 1'b0);
      repeat (DIV / 2) @(posedge clk);
      for (int i = 0; i < 10; i++) begin
         f[i] = line_in;
         repeat (DIV) @(posedge clk);
      end
      b = f[8:1];
      ok = f[0] === 1'b0 && f[9] === ^f[8:1] && line_in === 1'b1;
   endtask
endmodule // mrs_master

// file: modbus_rtu_slave_serial_link_test.sv
// Purpose: self-checking bench of the slave serial link
// Assumes: clock scaled to 1.25 MHz so a bit at 115200 is 11 cycles
// Notes: slave address 5, even parity, one and later two stop bits, reply wait of 2 steps
module modbus_rtu_slave_serial_link_test;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int DIV = 11;
   localparam int TICK = 10;
   logic clk, rstn, cfg_stop2, err_clr, rsp_wr, rsp_send;
   logic [2:0] cfg_rate;
   logic [1:0] cfg_parity;
   logic [4:0] cfg_addr;
   logic [13:0] cfg_wait;
   logic [3:0] cfg_err_limit, err_count;
   logic [7:0] rsp_data, rx_data;
   logic tx_pin, tx_oe, rx_valid, rx_end, rx_good, rx_bcast, rsp_pend, tx_busy, comm_alarm;
   logic last_good, last_bcast;
   logic [7:0] last_byte;
   wire rx_pin;
   wire line;
   int num_errors = 0, n_tests = 0, n_end = 0, oe_cnt = 0, oe_bad = 0, cyc = 0, n_byte = 0;

   // released line is pulled high by the bias network
   assign line = tx_oe ? tx_pin : 1'b1;

   mrs_link #(.CLK_HZ(1_250_000), .TICK_CYC(TICK)) i_mrs_link (.clk(clk), .rstn(rstn),
      .rx_pin(rx_pin), .cfg_rate(cfg_rate), .cfg_parity(cfg_parity), .cfg_stop2(cfg_stop2),
      .cfg_addr(cfg_addr), .cfg_wait(cfg_wait), .cfg_err_limit(cfg_err_limit),
      .err_clr(err_clr), .rsp_data(rsp_data), .rsp_wr(rsp_wr), .rsp_send(rsp_send),
      .tx_pin(tx_pin), .tx_oe(tx_oe), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_end(rx_end), .rx_good(rx_good), .rx_bcast(rx_bcast), .rsp_pend(rsp_pend),
      .tx_busy(tx_busy), .comm_alarm(comm_alarm), .err_count(err_count));

   mrs_master #(.DIV(DIV)) i_mrs_master (.clk(clk), .line_in(line), .line_out(rx_pin));

   always #4 clk = ~clk;

   // ==========================================================
   // frame-end catcher, driver watch and hang limit
   always @(posedge clk) begin
      if (rx_end === 1'b1) begin
         n_end++;
         last_good = rx_good;
         last_bcast = rx_bcast;
      end
      if (rx_valid === 1'b1) begin
         n_byte++;
         last_byte = rx_data;
      end
      if (tx_oe === 1'b1) oe_cnt++;
      if (tx_oe === 1'b1 && tx_busy !== 1'b1) oe_bad++;
      if (++cyc == 90000) begin
         num_errors++;
         wrap_up();
      end
   end

   task automatic chk(input logic ok, input string msg);
      n_tests++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask

   // bounded wait for the next frame end, then settle
   task automatic wait_end(input int n0);
      for (int i = 0; i < 4000 && n_end == n0; i++) @(posedge clk);
      #1;
   endtask

   // unicast query, two reply bytes, crc appended, timed driver window
   task automatic t_unicast();
      logic [7:0] b;
      logic ok;
      logic [15:0] c, qc;
      int k, n0, b0;
      n0 = n_end;
      b0 = n_byte;
      qc = i_mrs_master.crc(32'h0503_0001, 4);
      cfg_parity = mrs_pkg::PAR_ODD; // live change must not matter until power-up
      i_mrs_master.query(32'h0503_0001, 1'b0);
      wait_end(n0);
      chk(last_good === 1'b1 && last_bcast === 1'b0 && rsp_pend === 1'b1, "query");
      chk(n_byte - b0 == 6 && last_byte === qc[15:8], "rx bytes");
      rsp_data = 8'h05;
      rsp_wr = 1'b1;
      @(posedge clk) #1 rsp_data = 8'h03;
      @(posedge clk) #1 rsp_wr = 1'b0;
      rsp_send = 1'b1;
      @(posedge clk) #1 rsp_send = 1'b0;
      chk(tx_busy === 1'b1 && rsp_pend === 1'b0 && tx_oe === 1'b0, "send");
      for (k = 1; k < 100 && tx_oe !== 1'b1; k++) @(posedge clk) #1;
      k = k - 1;
      chk(k >= 2 * TICK + 1 && k <= 2 * TICK + 2, "reply wait");
      c = i_mrs_master.crc(32'h0000_0503, 2);
      for (int i = 0; i < 4; i++) begin
         i_mrs_master.get(b, ok);
         chk(ok && b === (i == 0 ? 8'h05 : i == 1 ? 8'h03 : i == 2 ? c[7:0] : c[15:8]), "rx");
      end
      for (int i = 0; i < 200 && tx_busy === 1'b1; i++) @(posedge clk) #1;
      chk(tx_oe === 1'b0 && tx_pin === 1'b1 && oe_bad == 0, "release");
      repeat (2500) @(posedge clk) #1;
   endtask

   // broadcast runs but never answers, even when a reply is pushed
   task automatic t_bcast();
      int n0, o0;
      n0 = n_end;
      o0 = oe_cnt;
      i_mrs_master.query(32'h0006_0002, 1'b0);
      wait_end(n0);
      chk(last_bcast === 1'b1 && last_good === 1'b1 && rsp_pend === 1'b0, "bcast");
      rsp_wr = 1'b1;
      rsp_send = 1'b1;
      @(posedge clk) #1 rsp_wr = 1'b0;
      rsp_send = 1'b0;
      repeat (300) @(posedge clk) #1;
      chk(oe_cnt == o0 && tx_busy === 1'b0, "bcast reply");
      repeat (2500) @(posedge clk) #1;
   endtask

   // a query for another slave leaves no trace
   task automatic t_other();
      int n0, b0;
      n0 = n_end;
      b0 = n_byte;
      i_mrs_master.query(32'h0703_0001, 1'b0);
      repeat (3000) @(posedge clk) #1;
      chk(n_end == n0 && n_byte == b0 && rsp_pend === 1'b0, "other addr");
   endtask

   // three bad frames reach the set limit of 3, then a clear
   task automatic t_errors();
      int n0;
      for (int i = 0; i < 3; i++) begin
         n0 = n_end;
         i_mrs_master.query(32'h0503_0001, 1'b1);
         wait_end(n0);
         chk(err_count === 4'(i + 1) && comm_alarm === (i == 2) && rsp_pend === 1'b0, "err");
         repeat (2500) @(posedge clk) #1;
      end
      err_clr = 1'b1;
      @(posedge clk) #1 err_clr = 1'b0;
      @(posedge clk) #1;
      chk(err_count === 4'h0 && comm_alarm === 1'b0, "clear");
   endtask

   // second power-up with two stop bits and parity back to even
   task automatic t_stop2();
      logic [7:0] b;
      logic ok;
      int n0, o0;
      cfg_parity = mrs_pkg::PAR_EVEN;
      cfg_stop2 = 1'b1;
      rstn = 1'b0;
      repeat (4) @(posedge clk) #1;
      rstn = 1'b1;
      repeat (3000) @(posedge clk) #1;
      n0 = n_end;
      i_mrs_master.query(32'h0506_0001, 1'b0);
      wait_end(n0);
      chk(last_good === 1'b1 && rsp_pend === 1'b1 && err_count === 4'h0, "query 2");
      o0 = oe_cnt;
      rsp_data = 8'h5A;
      rsp_wr = 1'b1;
      @(posedge clk) #1 rsp_wr = 1'b0;
      rsp_send = 1'b1;
      @(posedge clk) #1 rsp_send = 1'b0;
      i_mrs_master.get(b, ok);
      chk(ok && b === 8'h5A, "rx 2");
      for (int i = 0; i < 500 && tx_busy === 1'b1; i++) @(posedge clk) #1;
      // start, 8 data, parity, 2 stop per character, one stop-level cycle between
      chk(oe_cnt - o0 == 3 * 12 * DIV + 2, "two stop");
   endtask

   task automatic wrap_up();
      if (num_errors == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   initial begin
      {clk, rstn, err_clr, rsp_wr, rsp_send, cfg_stop2} = '0;
      rsp_data = 8'h00;
      cfg_rate = 3'h4;
      cfg_parity = mrs_pkg::PAR_EVEN;
      cfg_addr = 5'h05;
      cfg_wait = 14'h0002;
      cfg_err_limit = 4'h3;
      repeat (4) @(posedge clk);
      #1 rstn = 1'b1;
      repeat (3000) @(posedge clk) #1;
      t_unicast();
      t_bcast();
      t_other();
      t_errors();
      t_stop2();
      wrap_up();
   end
endmodule // modbus_rtu_slave_serial_link_test
